// File: bench/sensor_host_model.sv
// Host-side serial master for the sensor port: mode 3, MSB first.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps

module sensor_host_model (
    input  wire logic miso_i,
    output logic      sclk_o,
    output logic      mosi_o,
    output logic      chip_select_n_o
);
    logic [7:0] rq[$];

    initial begin
        sclk_o          = 1'b1;
        mosi_o          = 1'b1;
        chip_select_n_o = 1'b1;
    end

    // 320 ns per bit; the clock stands high outside frames
    task automatic xfer(input logic [7:0] o, output logic [7:0] r);
        for (int b = 7; b >= 0; b--) begin
            sclk_o = 1'b0;
            mosi_o = o[b];
            #160;
            r[b]   = miso_i;
            sclk_o = 1'b1;
            #160;
        end
        mosi_o = ~mosi_o; // Released line shows no stale bit
    endtask : xfer

    // Address, gap, n data bytes, then deselect well past the exit time
    task automatic frame(input logic [7:0] a, input logic [7:0] wd, input int n);
        logic [7:0] r;
        rq = {};
        chip_select_n_o = 1'b0;
        #400;
        xfer(a, r);
        #3000;
        for (int i = 0; i < n; i++) begin
            xfer(wd + 8'(i), r);
            rq.push_back(r);
        end
        #1000;
        chip_select_n_o = 1'b1;
        #1000;
    endtask : frame
endmodule : sensor_host_model

// File: bench/sensor_serial_burst_sequencer_sva.sv
// Checker for the sequencer's outputs.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/1ps

module sensor_port_checker (
    input wire logic        ref_clk_i,
    input wire logic        rstn_i,
    input wire logic        chip_select_n_i,
    input wire logic        miso_o,
    input wire logic        miso_oe_o,
    input wire logic        motion_clear_o,
    input wire logic        core_reset_o,
    input wire logic        capture_start_o,
    input wire logic        fw_write_o,
    input wire logic [11:0] fw_addr_o,
    input wire logic [9:0]  pixel_addr_o,
    input wire logic        nav_enable_o,
    input wire logic        emitter_enable_n_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // ----------------------------------------
    // Last firmware address, so the stream must step by one
    // ----------------------------------------
    logic [11:0] fw_last_q;
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            fw_last_q <= 12'h000;
        end else if (fw_write_o) begin
            fw_last_q <= fw_addr_o;
        end
    end
    a_port_released: assert property (chip_select_n_i [*5] |-> !miso_oe_o && !miso_o)
        else $error("miso active after deselect");
    a_port_driving: assert property (!chip_select_n_i [*5] |-> miso_oe_o)
        else $error("miso not driven while selected");
    a_clear_pulse: assert property (motion_clear_o |=> !motion_clear_o)
        else $error("motion clear longer than one cycle");
    a_reset_pulse: assert property (core_reset_o |=> !core_reset_o ##1 emitter_enable_n_o)
        else $error("soft reset pulse or emitter state wrong");
    a_fw_spacing: assert property (fw_write_o |=> !fw_write_o [*8])
        else $error("firmware bytes too close");
    a_fw_step: assert property (fw_write_o && fw_addr_o != 12'h000 |-> fw_addr_o == fw_last_q + 12'h001)
        else $error("firmware address skipped");
    a_fw_bound: assert property (fw_write_o |-> fw_addr_o < 12'hc00)
        else $error("firmware address beyond store");
    a_pixel_range: assert property (pixel_addr_o <= 10'h384)
        else $error("pixel index beyond frame");
    a_capture_nav: assert property (capture_start_o |-> ##2 !nav_enable_o)
        else $error("navigation kept after capture");
    c_fw: cover property (fw_write_o);
    c_capture: cover property (capture_start_o);
    c_reset: cover property (core_reset_o);
endmodule : sensor_port_checker

bind sensor_serial_burst_sequencer sensor_port_checker u_port_checker (.*);

// File: bench/test_sensor_serial_burst_sequencer.sv
// Self-checking bench for the sensor serial burst sequencer.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module test_sensor_serial_burst_sequencer;
    logic ref_clk_i, rstn_i, frame_tick_i, motion_i, tick_en, sclk, mosi, ncs_n;
    logic miso_o, miso_oe_o, motion_clear_o, capture_start_o, core_reset_o, fw_write_o;
    logic nav_enable_o, emitter_enable_n_o;
    logic [7:0]  health_flags_i, surface_quality_i, pixel_sum_i, pixel_max_i, pixel_min_i;
    logic [15:0] delta_x_i, delta_y_i, shutter_i, frame_period_i;
    logic [7:0]  pixel_data_i, fw_data_o, b;
    logic [9:0]  pixel_addr_o;
    logic [11:0] fw_addr_o;
    logic [19:0] fwq[$];
    logic [7:0]  e[$];
    int miscompares, comparisons, clr_cnt, rst_cnt, cap_cnt, cyc;

    sensor_host_model host (.miso_i(miso_o), .sclk_o(sclk), .mosi_o(mosi), .chip_select_n_o(ncs_n));
    sensor_serial_burst_sequencer uut (.sclk_i(sclk), .mosi_i(mosi), .chip_select_n_i(ncs_n), .*);

    // Imaging core stand-in: combinational pixel memory, one frame per 64 cycles
    assign pixel_data_i = pixel_addr_o[7:0] ^ 8'h5a;
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc          <= cyc + 1;
        frame_tick_i <= tick_en && (cyc % 64 == 0);
        if (motion_clear_o === 1'b1) clr_cnt++;
        if (core_reset_o === 1'b1) rst_cnt++;
        if (capture_start_o === 1'b1) cap_cnt++;
        if (fw_write_o === 1'b1) fwq.push_back({fw_addr_o, fw_data_o});
    end

    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.frame({1'b1, a}, d, 1);
    endtask : wr
    task automatic rd(input logic [6:0] a, input int n);
        host.frame({1'b0, a}, 8'h00, n);
    endtask : rd
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        #4_000_000;
        miscompares++;
        complete_run();
    end

    initial begin
        {rstn_i, tick_en, cyc, frame_tick_i} = '0;
        void'($urandom(32'h50c1));
        {motion_i, health_flags_i, delta_x_i, delta_y_i, surface_quality_i, pixel_sum_i, pixel_max_i,
            pixel_min_i, shutter_i, frame_period_i} <= 105'({$urandom, $urandom, $urandom, $urandom});
        repeat (2) @(posedge ref_clk_i);
        rstn_i  <= 1'b1;
        tick_en <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        check(emitter_enable_n_o, 1'b1);
        rd(sensor_pkg::A_COMPL_CODE, 1);
        check(host.rq[0], sensor_pkg::COMPL_CODE_VAL);
        rd(7'h39, 1);
        check(host.rq[0], sensor_pkg::FW_SIZE_RST);
        wr(7'h39, 8'(1 << sensor_pkg::FW_SIZE_3K_BIT));
        rd(7'h39, 1);
        check(host.rq[0], 8'(1 << sensor_pkg::FW_SIZE_3K_BIT));
        $display("register access test done");
        rd(7'h50, 16);
        e = {health_flags_i, delta_x_i[7:0], delta_x_i[15:8], delta_y_i[7:0], delta_y_i[15:8],
            surface_quality_i, pixel_sum_i, pixel_max_i, pixel_min_i, shutter_i[15:8],
            shutter_i[7:0], frame_period_i[15:8], frame_period_i[7:0], 8'h00, 8'h00};
        check(host.rq[0][7], motion_i);
        for (int i = 0; i < 15; i++) check(host.rq[i + 1], e[i]);
        wr(7'h02, 8'h00);
        check(clr_cnt, 1);
        host.frame(8'h82, 8'h00, 0);
        check(clr_cnt, 1);
        $display("motion burst test done");
        wr(sensor_pkg::A_FW_LOAD_CTRL, 8'h1d);
        wr(sensor_pkg::A_FW_LOAD_CTRL, 8'h18);
        b = 8'($urandom);
        host.frame({1'b1, sensor_pkg::A_FW_STREAM}, b, 6);
        check(fwq.size(), 6);
        foreach (fwq[i]) check(fwq[i], {12'(i), b + 8'(i)});
        check(nav_enable_o, 1'b0);
        $display("firmware stream test done");
        tick_en <= 1'b0;
        wr(sensor_pkg::A_CAPTURE, 8'h93);
        wr(sensor_pkg::A_CAPTURE, 8'hc5);
        check(cap_cnt, 1);
        check(nav_enable_o, 1'b0);
        rd(sensor_pkg::A_IMG_STREAM, 4);
        for (int i = 0; i < 4; i++) check(host.rq[i], 8'h00);
        tick_en <= 1'b1;
        repeat (200) @(posedge ref_clk_i);
        rd(7'h02, 1);
        check(host.rq[0][0], 1'b1);
        rd(sensor_pkg::A_IMG_STREAM, 902);
        for (int i = 0; i < 902; i++) check(host.rq[i], i < 900 ? 8'(i) ^ 8'h5a : 8'h00);
        $display("frame capture test done");
        wr(7'h20, 8'h00);
        check(emitter_enable_n_o, 1'b0);
        wr(7'h3b, 8'hb6);
        check(emitter_enable_n_o, 1'b1);
        wr(7'h02, 8'h00);
        check(clr_cnt, 1);
        wr(7'h3a, 8'h5a);
        check(rst_cnt, 1);
        wr(7'h02, 8'h00);
        check(clr_cnt, 2);
        wr(7'h24, 8'h00);
        rd(7'h24, 1);
        check(host.rq[0], health_flags_i);
        $display("shutdown test done");
        complete_run();
    end
endmodule : test_sensor_serial_burst_sequencer

// File: logic/pin_sync.sv
// Two-flop synchroniser for one pin that comes from outside the core clock.
// Assumes the pin may change at any time relative to ref_clk_i.
`timescale 1ns/1ps

module pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic pin_i,
    output logic      sync_o
);

    logic meta_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= pin_i;
            sync_o <= meta_q;
        end
    end

endmodule : pin_sync

// File: logic/sensor_pkg.sv
// Constants for the sensor serial port and its burst sequencer.
// Assumes a 25 MHz core clock and a host that masters the four-wire port.
//
// What this block does
// - First byte holds seven address bits; top bit high means write, low means read.
// - Chip select going high aborts any transaction and resets the port, at once outside bursts, after the burst exit time for a burst.
// - Burst bytes stream to or from one burst address, with no further address byte or gap.
// - A read of 0x50 starts a motion burst of up to 14 bytes.
// - Motion burst returns its fourteen bytes in the fixed documented order.
// - A burst ends only after chip select stays high for the burst exit time.
// - Register 0x39 selects 1.5K or 3K firmware download; default is 1.5K.
// - Frame capture stops navigation and discards firmware until reset and reload.
// - After motion bit 0 reads one, host bursts 900 pixels from the image stream.
// - Image stream reads before the image is ready return zero bytes.
// - Writing 0xb6 to 0x3b enters shutdown and drives the emitter enable high.
// - In shutdown every command except 0x5a to 0x3a is ignored.

package sensor_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS   = 40;
    localparam int BURST_EXIT_NS   = 500;
    localparam int BURST_EXIT_CYC  = (BURST_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAPTURE_FRAMES  = 2;

    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [6:0] A_MOTION_STATUS  = 7'h02;
    localparam logic [6:0] A_DX_LO          = 7'h03;
    localparam logic [6:0] A_DX_HI          = 7'h04;
    localparam logic [6:0] A_DY_LO          = 7'h05;
    localparam logic [6:0] A_DY_HI          = 7'h06;
    localparam logic [6:0] A_SURF_QUAL      = 7'h07;
    localparam logic [6:0] A_PIX_SUM        = 7'h08;
    localparam logic [6:0] A_PIX_MAX        = 7'h09;
    localparam logic [6:0] A_PIX_MIN        = 7'h0a;
    localparam logic [6:0] A_SHUT_LO        = 7'h0b;
    localparam logic [6:0] A_SHUT_HI        = 7'h0c;
    localparam logic [6:0] A_FP_LO          = 7'h0d;
    localparam logic [6:0] A_FP_HI          = 7'h0e;
    localparam logic [6:0] A_CAPTURE        = 7'h12;
    localparam logic [6:0] A_FW_LOAD_CTRL   = 7'h13;
    localparam logic [6:0] A_EMITTER_CTRL   = 7'h20;
    localparam logic [6:0] A_HEALTH         = 7'h24;
    localparam logic [6:0] A_FW_SIZE_CFG    = 7'h39;
    localparam logic [6:0] A_SOFT_RESET     = 7'h3a;
    localparam logic [6:0] A_SHUTDOWN       = 7'h3b;
    localparam logic [6:0] A_COMPL_CODE     = 7'h3f;
    localparam logic [6:0] A_MOVE_BURST     = 7'h50;
    localparam logic [6:0] A_FW_STREAM      = 7'h62;
    localparam logic [6:0] A_IMG_STREAM     = 7'h64;

    // ----------------------------------------
    // Command values, resets, fields
    // ----------------------------------------
    localparam logic [7:0] CMD_RESET        = 8'h5a;
    localparam logic [7:0] CMD_SHUTDOWN     = 8'hb6;
    localparam logic [7:0] CMD_FW_INIT      = 8'h1d;
    localparam logic [7:0] CMD_FW_START     = 8'h18;
    localparam logic [7:0] CMD_CAP_FIRST    = 8'h93;
    localparam logic [7:0] CMD_CAP_SECOND   = 8'hc5;
    localparam logic [7:0] EMITTER_RST      = 8'h01;
    localparam logic [7:0] FW_SIZE_RST      = 8'h00;
    localparam int         EMIT_OFF_BIT     = 0;
    localparam int         FW_SIZE_3K_BIT   = 1;
    localparam int         RW_BIT           = 7;
    // Arbitrary value, not tied to any real part
    localparam logic [7:0] COMPL_CODE_VAL   = 8'h5e;

    localparam logic [11:0] FW_LEN_SMALL    = 12'h600;
    localparam logic [11:0] FW_LEN_FULL     = 12'hc00;
    localparam logic [9:0]  PIXEL_COUNT     = 10'h384;
    localparam logic [3:0]  MB_LEN          = 4'he;

    // Register read order of the motion burst
    localparam logic [6:0] MB_ORDER [14] = '{
        A_MOTION_STATUS, A_HEALTH, A_DX_LO, A_DX_HI, A_DY_LO, A_DY_HI, A_SURF_QUAL,
        A_PIX_SUM, A_PIX_MAX, A_PIX_MIN, A_SHUT_HI, A_SHUT_LO, A_FP_HI, A_FP_LO
    };

    typedef enum logic [2:0] {
        ST_ADDR   = 3'b000,
        ST_WDATA  = 3'b001,
        ST_RDATA  = 3'b010,
        ST_FBURST = 3'b011,
        ST_LOCKED = 3'b100
    } port_state_e;

    typedef enum logic [1:0] {
        BK_NONE   = 2'b00,
        BK_MOTION = 2'b01,
        BK_PIXEL  = 2'b10
    } burst_kind_e;

endpackage : sensor_pkg

// File: logic/sensor_serial_burst_sequencer.sv
// Device side of the sensor serial port: register access, bursts, capture, shutdown.
// Assumes serial pins arrive asynchronously and the imaging core supplies the values.
`timescale 1ns/1ps

module sensor_serial_burst_sequencer (
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        sclk_i,
    input  wire logic        mosi_i,
    input  wire logic        chip_select_n_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    input  wire logic        frame_tick_i,
    input  wire logic        motion_i,
    input  wire logic [7:0]  health_flags_i,
    input  wire logic [15:0] delta_x_i,
    input  wire logic [15:0] delta_y_i,
    input  wire logic [7:0]  surface_quality_i,
    input  wire logic [7:0]  pixel_sum_i,
    input  wire logic [7:0]  pixel_max_i,
    input  wire logic [7:0]  pixel_min_i,
    input  wire logic [15:0] shutter_i,
    input  wire logic [15:0] frame_period_i,
    input  wire logic [7:0]  pixel_data_i,
    output logic [9:0]       pixel_addr_o,
    output logic             motion_clear_o,
    output logic             capture_start_o,
    output logic             core_reset_o,
    output logic             fw_write_o,
    output logic [11:0]      fw_addr_o,
    output logic [7:0]       fw_data_o,
    output logic             nav_enable_o,
    output logic             emitter_enable_n_o
);

    // ----------------------------------------
    // Pin synchronisers and edges
    // ----------------------------------------
    logic sclk_s, mosi_s, ncs_s, sclk_d_q;

    pin_sync #(.RST_VAL(1'b1)) u_sync_sclk (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(sclk_i), .sync_o(sclk_s));
    pin_sync #(.RST_VAL(1'b0)) u_sync_mosi (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(mosi_i), .sync_o(mosi_s));
    pin_sync #(.RST_VAL(1'b1)) u_sync_ncs (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(chip_select_n_i), .sync_o(ncs_s));

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            sclk_d_q <= 1'b1;
        end else begin
            sclk_d_q <= sclk_s;
        end
    end

    logic sclk_rise, sclk_fall;
    assign sclk_rise = ~ncs_s & sclk_s & ~sclk_d_q;
    assign sclk_fall = ~ncs_s & ~sclk_s & sclk_d_q;

    // ----------------------------------------
    // Port state
    // ----------------------------------------
    sensor_pkg::port_state_e state_q;
    sensor_pkg::burst_kind_e burst_q;
    logic [7:0]  rx_q;
    logic [2:0]  bit_cnt_q;
    logic [6:0]  addr_q;
    logic        wr_q;
    logic [7:0]  rx_next;
    logic        byte_done;
    logic [$clog2(sensor_pkg::BURST_EXIT_CYC+1)-1:0] exit_cnt_q;
    logic        shutdown_q;
    logic        fw_armed_q;

    assign rx_next   = {rx_q[6:0], mosi_s};
    assign byte_done = sclk_rise & (bit_cnt_q == 3'h7);

    logic addr_done, wr_fire, rd_start;
    assign addr_done = byte_done & (state_q == sensor_pkg::ST_ADDR);
    // Shutdown lets only writes to the soft reset register through
    assign wr_fire   = byte_done & (state_q == sensor_pkg::ST_WDATA) & wr_q &
                       (~shutdown_q | (addr_q == sensor_pkg::A_SOFT_RESET));
    assign rd_start  = addr_done & ~rx_next[sensor_pkg::RW_BIT] & ~shutdown_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_q    <= sensor_pkg::ST_ADDR;
            burst_q    <= sensor_pkg::BK_NONE;
            rx_q       <= 8'h00;
            bit_cnt_q  <= 3'h0;
            addr_q     <= 7'h00;
            wr_q       <= 1'b0;
            exit_cnt_q <= '0;
        end else if (ncs_s) begin
            // Bursts stay locked until chip select has been high long enough
            rx_q      <= 8'h00;
            bit_cnt_q <= 3'h0;
            if (state_q == sensor_pkg::ST_LOCKED || state_q == sensor_pkg::ST_FBURST ||
                burst_q != sensor_pkg::BK_NONE) begin
                state_q <= sensor_pkg::ST_LOCKED;
                if (exit_cnt_q == ($bits(exit_cnt_q))'(sensor_pkg::BURST_EXIT_CYC - 1)) begin
                    state_q    <= sensor_pkg::ST_ADDR;
                    burst_q    <= sensor_pkg::BK_NONE;
                    exit_cnt_q <= '0;
                end else begin
                    exit_cnt_q <= exit_cnt_q + 1'b1;
                end
            end else begin
                state_q <= sensor_pkg::ST_ADDR;
            end
        end else begin
            exit_cnt_q <= '0;
            if (sclk_rise && state_q != sensor_pkg::ST_LOCKED) begin
                rx_q      <= rx_next;
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (addr_done) begin
                addr_q <= rx_next[6:0];
                wr_q   <= rx_next[sensor_pkg::RW_BIT];
                if (rd_start && rx_next[6:0] == sensor_pkg::A_MOVE_BURST) begin
                    state_q <= sensor_pkg::ST_RDATA;
                    burst_q <= sensor_pkg::BK_MOTION;
                end else if (rd_start && rx_next[6:0] == sensor_pkg::A_IMG_STREAM) begin
                    state_q <= sensor_pkg::ST_RDATA;
                    burst_q <= sensor_pkg::BK_PIXEL;
                end else if (rd_start) begin
                    state_q <= sensor_pkg::ST_RDATA;
                end else if (rx_next[sensor_pkg::RW_BIT] && fw_armed_q && ~shutdown_q &&
                             rx_next[6:0] == sensor_pkg::A_FW_STREAM) begin
                    state_q <= sensor_pkg::ST_FBURST;
                end else begin
                    // Reads in shutdown are swallowed as a discarded byte
                    state_q <= sensor_pkg::ST_WDATA;
                end
            end else if (byte_done && state_q == sensor_pkg::ST_WDATA) begin
                state_q <= sensor_pkg::ST_ADDR;
            end else if (byte_done && state_q == sensor_pkg::ST_RDATA &&
                         burst_q == sensor_pkg::BK_NONE) begin
                state_q <= sensor_pkg::ST_ADDR;
            end
        end
    end

    // ----------------------------------------
    // Register read path and MISO
    // ----------------------------------------
    logic       image_ready_q, miso_q, capture_go;
    logic [7:0] emitter_q, fw_size_q, tx_q;

    function automatic logic [7:0] reg_byte(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            sensor_pkg::A_MOTION_STATUS: v = {motion_i, 6'h00, image_ready_q};
            sensor_pkg::A_HEALTH:        v = health_flags_i;
            sensor_pkg::A_DX_LO:         v = delta_x_i[7:0];
            sensor_pkg::A_DX_HI:         v = delta_x_i[15:8];
            sensor_pkg::A_DY_LO:         v = delta_y_i[7:0];
            sensor_pkg::A_DY_HI:         v = delta_y_i[15:8];
            sensor_pkg::A_SURF_QUAL:     v = surface_quality_i;
            sensor_pkg::A_PIX_SUM:       v = pixel_sum_i;
            sensor_pkg::A_PIX_MAX:       v = pixel_max_i;
            sensor_pkg::A_PIX_MIN:       v = pixel_min_i;
            sensor_pkg::A_SHUT_LO:       v = shutter_i[7:0];
            sensor_pkg::A_SHUT_HI:       v = shutter_i[15:8];
            sensor_pkg::A_FP_LO:         v = frame_period_i[7:0];
            sensor_pkg::A_FP_HI:         v = frame_period_i[15:8];
            sensor_pkg::A_EMITTER_CTRL:  v = emitter_q;
            sensor_pkg::A_FW_SIZE_CFG:   v = fw_size_q;
            sensor_pkg::A_COMPL_CODE:    v = sensor_pkg::COMPL_CODE_VAL;
            default:                     v = 8'h00;
        endcase
        return v;
    endfunction : reg_byte

    logic [3:0] mb_idx_q;
    logic [9:0] pix_idx_q;
    logic [7:0] pix_byte;
    logic       load_next;

    // Pixel memory sits in the imaging core and answers pixel_addr_o in the same cycle
    assign pix_byte  = (image_ready_q && pix_idx_q < sensor_pkg::PIXEL_COUNT) ?
                       pixel_data_i : 8'h00;
    assign load_next = byte_done & (state_q == sensor_pkg::ST_RDATA) & ~ncs_s;
    assign pixel_addr_o = pix_idx_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i || ncs_s) begin
            tx_q      <= 8'h00;
            mb_idx_q  <= 4'h0;
            miso_q    <= 1'b0;
        end else if (rd_start && rx_next[6:0] == sensor_pkg::A_MOVE_BURST) begin
            tx_q     <= reg_byte(sensor_pkg::MB_ORDER[0]);
            mb_idx_q <= 4'h1;
        end else if (rd_start && rx_next[6:0] == sensor_pkg::A_IMG_STREAM) begin
            tx_q <= pix_byte;
        end else if (rd_start) begin
            tx_q <= reg_byte(rx_next[6:0]);
        end else if (load_next && burst_q == sensor_pkg::BK_MOTION) begin
            // Next byte follows with no gap and no address
            tx_q     <= (mb_idx_q < sensor_pkg::MB_LEN) ?
                        reg_byte(sensor_pkg::MB_ORDER[mb_idx_q]) : 8'h00;
            mb_idx_q <= (mb_idx_q < sensor_pkg::MB_LEN) ? mb_idx_q + 4'h1 : mb_idx_q;
        end else if (load_next && burst_q == sensor_pkg::BK_PIXEL) begin
            tx_q <= pix_byte;
        end else if (sclk_fall && state_q == sensor_pkg::ST_RDATA) begin
            miso_q <= tx_q[7];
            tx_q   <= {tx_q[6:0], 1'b0};
        end
    end

    assign miso_o    = miso_q;
    assign miso_oe_o = ~ncs_s;

    // ----------------------------------------
    // Configuration, commands and shutdown
    // ----------------------------------------
    logic soft_rst;
    assign soft_rst = wr_fire & (addr_q == sensor_pkg::A_SOFT_RESET) &
                      (rx_next == sensor_pkg::CMD_RESET);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i || soft_rst) begin
            emitter_q  <= sensor_pkg::EMITTER_RST;
            fw_size_q  <= sensor_pkg::FW_SIZE_RST;
            shutdown_q <= 1'b0;
        end else if (wr_fire) begin
            if (addr_q == sensor_pkg::A_EMITTER_CTRL) begin
                emitter_q <= rx_next;
            end
            if (addr_q == sensor_pkg::A_FW_SIZE_CFG) begin
                fw_size_q <= rx_next;
            end
            if (addr_q == sensor_pkg::A_SHUTDOWN && rx_next == sensor_pkg::CMD_SHUTDOWN) begin
                shutdown_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            motion_clear_o     <= 1'b0;
            core_reset_o       <= 1'b0;
            emitter_enable_n_o <= 1'b1;
        end else begin
            motion_clear_o     <= wr_fire & (addr_q == sensor_pkg::A_MOTION_STATUS);
            core_reset_o       <= soft_rst;
            emitter_enable_n_o <= shutdown_q | emitter_q[sensor_pkg::EMIT_OFF_BIT];
        end
    end

    // ----------------------------------------
    // Firmware download
    // ----------------------------------------
    logic        fw_init_q, fw_valid_q;
    logic [11:0] fw_cnt_q;
    logic [11:0] fw_len;
    logic        fw_byte;
    assign fw_len  = fw_size_q[sensor_pkg::FW_SIZE_3K_BIT] ?
                     sensor_pkg::FW_LEN_FULL : sensor_pkg::FW_LEN_SMALL;
    assign fw_byte = byte_done & (state_q == sensor_pkg::ST_FBURST) & (fw_cnt_q < fw_len);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i || soft_rst || capture_go) begin
            fw_init_q  <= 1'b0;
            fw_armed_q <= 1'b0;
            fw_valid_q <= 1'b0;
            fw_cnt_q   <= 12'h000;
            fw_write_o <= 1'b0;
            fw_addr_o  <= 12'h000;
            fw_data_o  <= 8'h00;
        end else begin
            fw_write_o <= fw_byte;
            if (wr_fire && addr_q == sensor_pkg::A_FW_LOAD_CTRL) begin
                fw_init_q  <= (rx_next == sensor_pkg::CMD_FW_INIT);
                fw_armed_q <= fw_init_q & (rx_next == sensor_pkg::CMD_FW_START);
                fw_valid_q <= 1'b0;
                fw_cnt_q   <= 12'h000;
            end
            if (fw_byte) begin
                fw_addr_o <= fw_cnt_q;
                fw_data_o <= rx_next;
                fw_cnt_q  <= fw_cnt_q + 12'h001;
                if (fw_cnt_q == fw_len - 12'h001) begin
                    fw_valid_q <= 1'b1;
                    fw_armed_q <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Frame capture
    // ----------------------------------------
    logic       cap_armed_q, cap_dirty_q;
    logic [1:0] cap_wait_q;
    assign capture_go = wr_fire & (addr_q == sensor_pkg::A_CAPTURE) & cap_armed_q &
                        (rx_next == sensor_pkg::CMD_CAP_SECOND);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i || soft_rst) begin
            cap_armed_q     <= 1'b0;
            cap_dirty_q     <= 1'b0;
            cap_wait_q      <= 2'h0;
            image_ready_q   <= 1'b0;
            pix_idx_q       <= 10'h000;
            capture_start_o <= 1'b0;
            nav_enable_o    <= 1'b0;
        end else begin
            capture_start_o <= capture_go;
            nav_enable_o    <= fw_valid_q & ~cap_dirty_q & ~capture_go;
            if (wr_fire && addr_q == sensor_pkg::A_CAPTURE) begin
                cap_armed_q <= (rx_next == sensor_pkg::CMD_CAP_FIRST);
            end
            if (capture_go) begin
                cap_dirty_q   <= 1'b1;
                image_ready_q <= 1'b0;
                pix_idx_q     <= 10'h000;
                cap_wait_q    <= 2'(sensor_pkg::CAPTURE_FRAMES);
            end else if (frame_tick_i && cap_wait_q != 2'h0) begin
                cap_wait_q <= cap_wait_q - 2'h1;
                if (cap_wait_q == 2'h1) begin
                    image_ready_q <= 1'b1;
                end
            end
            if (image_ready_q && pix_idx_q < sensor_pkg::PIXEL_COUNT &&
                ((rd_start && rx_next[6:0] == sensor_pkg::A_IMG_STREAM) ||
                 (load_next && burst_q == sensor_pkg::BK_PIXEL))) begin
                pix_idx_q <= pix_idx_q + 10'h001;
            end
        end
    end

endmodule : sensor_serial_burst_sequencer
